// [motor_model.sv]
// Servo motor with holding brake as seen by the sequencer
module motor_model (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Drive side
	input wire logic drive_en_i,
	input wire logic brake_i,
	input wire logic signed [15:0] cmd_i,
	input wire logic [7:0] decel_i,
	// Encoder
	output logic signed [15:0] speed_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic signed [15:0] dec;
	assign dec = $signed({8'h00, decel_i});
	// Coasting only loses speed by friction; a held brake stops the shaft once drive_en_i is low
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			speed_o <= 16'sh0000;
		else if (drive_en_i)
			speed_o <= cmd_i;
		else if (brake_i)
			speed_o <= 16'sh0000;
		else if (speed_o > dec)
			speed_o <= speed_o - dec;
		else if (dec != 16'sh0000)
			speed_o <= 16'sh0000;
	end
endmodule

// [servo_brake_defines.svh]
// Constants of the servo brake sequencer
`ifndef SERVO_BRAKE_DEFINES_SVH
`define SERVO_BRAKE_DEFINES_SVH

`define CLK_HZ 10000000
`define TICK_MS 10
`define TICK_CYCLES (`CLK_HZ / 1000 * `TICK_MS)

`define OFS_CTRL 8'h00
`define OFS_SOFF_DLY 8'h04
`define OFS_BRK_THR 8'h08
`define OFS_STOP_DLY 8'h0C
`define OFS_OVL_SENS 8'h10
`define OFS_STATUS 8'h14
`define OFS_IRQ_STAT 8'h18
`define OFS_IRQ_CLR 8'h1C
`define OFS_IRQ_EN 8'h20

`define CTRL_UNLOCK_BIT 0
`define CTRL_DIR_BIT 1
`define DIR_RESET 1'h1
`define SOFF_DLY_RESET 9'h000
`define SOFF_DLY_MAX 9'h1F4
`define BRK_THR_RESET 15'h03E8
`define BRK_THR_MAX 15'h7530
`define STOP_DLY_RESET 7'h32
`define STOP_DLY_MIN 7'h0A
`define STOP_DLY_MAX 7'h64
`define OVL_SENS_RESET 15'h0064
`define OVL_SENS_MIN 15'h0001
`define OVL_SENS_MAX 15'h7530
`define STATIC_SPEED 16'h00C8

`define IRQ_DISABLED 0
`define IRQ_BRAKE 1
`define IRQ_ALARM 2
`define IRQ_OVERLOAD 3
`define IRQ_REFUSED 4
`define IRQ_W 5

`endif

// [servo_brake_pkg.sv]
// Types of the servo brake sequencer
package servo_brake_pkg;
	typedef enum logic [1:0] {
		ST_OFF,
		ST_ON,
		ST_SOFF_WAIT,
		ST_COAST
	} seq_state_t;
endpackage

// [servo_brake_sequencer.sv]
// Holding brake and servo disable sequencer with APB registers
//
// Decided for this implementation: the APB slave port and the address map.
`include "servo_brake_defines.svh"
module servo_brake_sequencer #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Drive side inputs
	input wire logic servo_on_i,
	input wire logic alarm_i,
	input wire logic overload_i,
	input wire logic signed [15:0] speed_i,
	// Motor side outputs
	output logic drive_en_o,
	output logic brake_o,
	output logic dir_ccw_o,
	output logic static_o,
	output logic overload_trip_o,
	output logic irq_o
);
	localparam int PW = $clog2(TICK_CYCLES);

	servo_brake_pkg::seq_state_t state_reg;
	logic [1:0] son_sync_reg;
	logic [1:0] alm_sync_reg;
	logic [1:0] ovl_sync_reg;
	logic unlock_reg;
	logic dir_sel_reg;
	logic [8:0] soff_dly_reg;
	logic [14:0] brk_thr_reg;
	logic [6:0] stop_dly_reg;
	logic [14:0] ovl_sens_reg;
	logic [`IRQ_W-1:0] irq_stat_reg;
	logic [`IRQ_W-1:0] irq_en_reg;
	logic [`IRQ_W-1:0] irq_ev;
	logic [`IRQ_W-1:0] irq_clr;
	logic [15:0] spd_abs;
	logic above_thr;
	logic fault;
	logic alarm_d_reg;
	logic trip_d_reg;
	logic [PW-1:0] pre_reg;
	logic tick_reg;
	logic [15:0] ovl_acc_reg;
	logic timer_start;
	logic [8:0] timer_units;
	logic timer_done;
	logic wr_en;
	logic rd_setup;
	logic refused;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, `OFS_CTRL) || hit(a, `OFS_SOFF_DLY) || hit(a, `OFS_BRK_THR)
			|| hit(a, `OFS_STOP_DLY) || hit(a, `OFS_OVL_SENS) || hit(a, `OFS_STATUS)
			|| hit(a, `OFS_IRQ_STAT) || hit(a, `OFS_IRQ_CLR) || hit(a, `OFS_IRQ_EN);
	endfunction

	// Pins cross in through two flops
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			son_sync_reg <= 2'h0;
			alm_sync_reg <= 2'h0;
			ovl_sync_reg <= 2'h0;
		end else begin
			son_sync_reg <= {son_sync_reg[0], servo_on_i};
			alm_sync_reg <= {alm_sync_reg[0], alarm_i};
			ovl_sync_reg <= {ovl_sync_reg[0], overload_i};
		end
	end

	// Speed magnitude, direction does not matter for braking
	assign spd_abs = speed_i[15] ? 16'(-speed_i) : 16'(speed_i);
	assign above_thr = spd_abs > {1'b0, brk_thr_reg};
	assign fault = alm_sync_reg[1] | overload_trip_o;

	// APB: one wait-free access, answer registered in setup
	assign rd_setup = psel_i & ~penable_i;
	assign wr_en = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
	assign refused = wr_en & hit(paddr_i, `OFS_OVL_SENS) & ~unlock_reg;
	assign irq_clr = (wr_en & hit(paddr_i, `OFS_IRQ_CLR)) ? pwdata_i[`IRQ_W-1:0] : '0;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= rd_setup;
			pslverr_o <= rd_setup & ~mapped(paddr_i);
			prdata_o <= 32'h0000_0000;
			if (rd_setup && !pwrite_i) begin
				case (paddr_i)
					`OFS_CTRL: prdata_o <= {30'h0, dir_sel_reg, unlock_reg};
					`OFS_SOFF_DLY: prdata_o <= {23'h0, soff_dly_reg};
					`OFS_BRK_THR: prdata_o <= {17'h0, brk_thr_reg};
					`OFS_STOP_DLY: prdata_o <= {25'h0, stop_dly_reg};
					`OFS_OVL_SENS: prdata_o <= {17'h0, ovl_sens_reg};
					`OFS_STATUS: prdata_o <= {25'h0, state_reg, son_sync_reg[1], overload_trip_o,
						brake_o, drive_en_o, static_o};
					`OFS_IRQ_STAT: prdata_o <= {27'h0, irq_stat_reg};
					`OFS_IRQ_EN: prdata_o <= {27'h0, irq_en_reg};
					default: prdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control bits
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			unlock_reg <= 1'b0;
			dir_sel_reg <= `DIR_RESET;
		end else if (wr_en && hit(paddr_i, `OFS_CTRL)) begin
			unlock_reg <= pwdata_i[`CTRL_UNLOCK_BIT];
			dir_sel_reg <= pwdata_i[`CTRL_DIR_BIT];
		end
	end

	// Timing settings, out-of-range writes clamp to the nearest limit
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			soff_dly_reg <= `SOFF_DLY_RESET;
		end else if (wr_en && hit(paddr_i, `OFS_SOFF_DLY)) begin
			soff_dly_reg <= (pwdata_i > 32'(`SOFF_DLY_MAX)) ? `SOFF_DLY_MAX : pwdata_i[8:0];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			brk_thr_reg <= `BRK_THR_RESET;
		end else if (wr_en && hit(paddr_i, `OFS_BRK_THR)) begin
			brk_thr_reg <= (pwdata_i > 32'(`BRK_THR_MAX)) ? `BRK_THR_MAX : pwdata_i[14:0];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stop_dly_reg <= `STOP_DLY_RESET;
		end else if (wr_en && hit(paddr_i, `OFS_STOP_DLY)) begin
			if (pwdata_i > 32'(`STOP_DLY_MAX))
				stop_dly_reg <= `STOP_DLY_MAX;
			else if (pwdata_i < 32'(`STOP_DLY_MIN))
				stop_dly_reg <= `STOP_DLY_MIN;
			else
				stop_dly_reg <= pwdata_i[6:0];
		end
	end

	// Motor parameter group, guarded by the unlock bit
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovl_sens_reg <= `OVL_SENS_RESET;
		end else if (wr_en && hit(paddr_i, `OFS_OVL_SENS) && unlock_reg) begin
			if (pwdata_i > 32'(`OVL_SENS_MAX))
				ovl_sens_reg <= `OVL_SENS_MAX;
			else if (pwdata_i < 32'(`OVL_SENS_MIN))
				ovl_sens_reg <= `OVL_SENS_MIN;
			else
				ovl_sens_reg <= pwdata_i[14:0];
		end
	end

	// Free 10 ms tick for the overload integrator
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pre_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (pre_reg == PW'(TICK_CYCLES - 1));
			pre_reg <= (pre_reg == PW'(TICK_CYCLES - 1)) ? '0 : pre_reg + PW'(1);
		end
	end

	// Overload integrates up while overloaded and bleeds off otherwise
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovl_acc_reg <= 16'h0000;
			overload_trip_o <= 1'b0;
		end else begin
			if (tick_reg) begin
				if (ovl_sync_reg[1] && ovl_acc_reg != 16'hFFFF)
					ovl_acc_reg <= ovl_acc_reg + 16'h0001;
				else if (!ovl_sync_reg[1] && ovl_acc_reg != 16'h0000)
					ovl_acc_reg <= ovl_acc_reg - 16'h0001;
			end
			// Trip holds until the integrator has fully drained
			if (ovl_acc_reg >= {1'b0, ovl_sens_reg})
				overload_trip_o <= 1'b1;
			else if (ovl_acc_reg == 16'h0000)
				overload_trip_o <= 1'b0;
		end
	end

	// Brake and disable sequence
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= servo_brake_pkg::ST_OFF;
			drive_en_o <= 1'b0;
			brake_o <= 1'b1;
		end else begin
			case (state_reg)
				servo_brake_pkg::ST_OFF: begin
					if (son_sync_reg[1] && !fault) begin
						state_reg <= servo_brake_pkg::ST_ON;
						drive_en_o <= 1'b1;
						brake_o <= 1'b0;
					end
				end
				servo_brake_pkg::ST_ON: begin
					if (fault && above_thr) begin
						state_reg <= servo_brake_pkg::ST_COAST;
						drive_en_o <= 1'b0;
					end else if (fault) begin
						state_reg <= servo_brake_pkg::ST_OFF;
						drive_en_o <= 1'b0;
						brake_o <= 1'b1;
					end else if (!son_sync_reg[1] && above_thr) begin
						state_reg <= servo_brake_pkg::ST_COAST;
						drive_en_o <= 1'b0;
					end else if (!son_sync_reg[1]) begin
						state_reg <= servo_brake_pkg::ST_SOFF_WAIT;
						brake_o <= 1'b1;
					end
				end
				servo_brake_pkg::ST_SOFF_WAIT: begin
					// Torque held against the closing brake until the delay ends or a fault arrives
					if (fault || timer_done) begin
						state_reg <= servo_brake_pkg::ST_OFF;
						drive_en_o <= 1'b0;
					end
				end
				servo_brake_pkg::ST_COAST: begin
					if (!above_thr || timer_done) begin
						state_reg <= servo_brake_pkg::ST_OFF;
						brake_o <= 1'b1;
					end
				end
				default: begin
					state_reg <= servo_brake_pkg::ST_OFF;
					drive_en_o <= 1'b0;
					brake_o <= 1'b1;
				end
			endcase
		end
	end

	// One timer serves both delays, they never overlap
	always_comb begin
		timer_start = 1'b0;
		timer_units = soff_dly_reg;
		if (state_reg == servo_brake_pkg::ST_ON && !son_sync_reg[1] && !fault && !above_thr) begin
			timer_start = 1'b1;
			timer_units = soff_dly_reg;
		end else if (state_reg == servo_brake_pkg::ST_ON && above_thr && (fault || !son_sync_reg[1])) begin
			timer_start = 1'b1;
			timer_units = {2'h0, stop_dly_reg};
		end
	end

	tick_timer #(
		.TICK_CYCLES(TICK_CYCLES),
		.W(9)
	) delay_timer (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.start_i(timer_start),
		.units_i(timer_units),
		.done_o(timer_done)
	);

	// Status outputs
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			static_o <= 1'b1;
			dir_ccw_o <= `DIR_RESET;
		end else begin
			static_o <= spd_abs < `STATIC_SPEED;
			dir_ccw_o <= dir_sel_reg;
		end
	end

	// Sticky events, a new event beats a clear in the same cycle
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alarm_d_reg <= 1'b0;
			trip_d_reg <= 1'b0;
		end else begin
			alarm_d_reg <= alm_sync_reg[1];
			trip_d_reg <= overload_trip_o;
		end
	end

	assign irq_ev[`IRQ_DISABLED] = (state_reg != servo_brake_pkg::ST_OFF) && !drive_en_o && !brake_o;
	assign irq_ev[`IRQ_BRAKE] = (state_reg == servo_brake_pkg::ST_COAST) && (!above_thr || timer_done);
	assign irq_ev[`IRQ_ALARM] = alm_sync_reg[1] & ~alarm_d_reg;
	assign irq_ev[`IRQ_OVERLOAD] = overload_trip_o & ~trip_d_reg;
	assign irq_ev[`IRQ_REFUSED] = refused;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_stat_reg <= '0;
			irq_en_reg <= '0;
			irq_o <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
			if (wr_en && hit(paddr_i, `OFS_IRQ_EN))
				irq_en_reg <= pwdata_i[`IRQ_W-1:0];
			irq_o <= |(irq_stat_reg & irq_en_reg);
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	unlock_gate_a: assert property (refused |=> $stable(ovl_sens_reg))
		else $error("locked motor parameter write changed sensitivity");
	sens_range_a: assert property (ovl_sens_reg >= 15'h0001 && ovl_sens_reg <= 15'h7530)
		else $error("overload sensitivity out of range");
	dir_follow_a: assert property (wr_en && hit(paddr_i, `OFS_CTRL) |=> ##1 dir_ccw_o == $past(pwdata_i[1], 2))
		else $error("direction output did not follow write");
	static_cls_a: assert property (1 |=> static_o == ($past(spd_abs) < 16'h00C8))
		else $error("static classification wrong");
	soff_brake_a: assert property (state_reg == servo_brake_pkg::ST_ON && !son_sync_reg[1] && !fault
		&& !above_thr |=> brake_o && drive_en_o)
		else $error("servo off did not brake before disable");
	thr_range_a: assert property (brk_thr_reg <= 15'h7530)
		else $error("brake threshold out of range");
	alarm_off_a: assert property (state_reg == servo_brake_pkg::ST_ON && fault && !above_thr
		|=> !drive_en_o && brake_o)
		else $error("alarm did not disable at once");
	coast_free_a: assert property (state_reg == servo_brake_pkg::ST_ON && fault && above_thr
		|=> !drive_en_o && !brake_o)
		else $error("fast alarm did not coast");
	coast_brake_a: assert property (state_reg == servo_brake_pkg::ST_COAST && !above_thr |=> brake_o)
		else $error("brake not engaged at threshold");
	stop_range_a: assert property (stop_dly_reg >= 7'h0A && stop_dly_reg <= 7'h64)
		else $error("brake stop delay out of range");
endmodule

// [tb.sv]
// Self-checking bench for the servo brake sequencer
`include "servo_brake_defines.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 10;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err;
	logic servo_on = 1'b0, alarm = 1'b0, overload = 1'b0;
	logic signed [15:0] speed, cmd = 16'sh0000;
	logic [7:0] decel = 8'h00;
	logic drive_en, brake, dir_ccw, is_static, trip, irq;
	int n_fail = 0, n_checks = 0, n;
	row_t rows [18] = '{
		'{0, `OFS_CTRL, 0, 32'h2, 0}, '{0, `OFS_SOFF_DLY, 0, 0, 0},
		'{0, `OFS_BRK_THR, 0, 32'h3E8, 0}, '{0, `OFS_STOP_DLY, 0, 32'h32, 0},
		'{1, `OFS_OVL_SENS, 32'h1F4, 32'h64, 0}, '{0, `OFS_IRQ_STAT, 0, 32'h10, 0},
		'{1, `OFS_CTRL, 32'h3, 32'h3, 0}, '{1, `OFS_OVL_SENS, 0, 32'h1, 0},
		'{1, `OFS_OVL_SENS, 32'h7918, 32'h7530, 0}, '{1, `OFS_SOFF_DLY, 32'h1FE, 32'h1F4, 0},
		'{1, `OFS_STOP_DLY, 32'h5, 32'hA, 0}, '{1, `OFS_STOP_DLY, 32'h65, 32'h64, 0},
		'{1, `OFS_BRK_THR, 32'h7531, 32'h7530, 0}, '{1, 8'h24, 32'h1, 32'h0, 1},
		'{1, `OFS_BRK_THR, 32'hC8, 32'hC8, 0}, '{1, `OFS_SOFF_DLY, 32'h2, 32'h2, 0},
		'{1, `OFS_STOP_DLY, 32'hA, 32'hA, 0}, '{1, `OFS_IRQ_CLR, 32'h1F, 32'h0, 0}};
	logic signed [15:0] spd [5] = '{16'sd199, 16'sd200, -16'sd150, -16'sd250, 16'sd0};
	logic st_exp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

	always #50 clk = ~clk;

	servo_brake_sequencer #(.TICK_CYCLES(TK)) dut (.ref_clk_i(clk), .rstn_i(rstn), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .servo_on_i(servo_on), .alarm_i(alarm),
		.overload_i(overload), .speed_i(speed), .drive_en_o(drive_en), .brake_o(brake),
		.dir_ccw_o(dir_ccw), .static_o(is_static), .overload_trip_o(trip), .irq_o(irq));
	motor_model motor (.ref_clk_i(clk), .rstn_i(rstn), .drive_en_i(drive_en), .brake_i(brake),
		.cmd_i(cmd), .decel_i(decel), .speed_o(speed));

	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		n_checks++;
		if (g < lo || g > hi) begin
			n_fail++;
			$display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	// Answer taken at the rising edge that sees pready, request dropped at that same edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return drive_en;
			1: return brake;
			2: return trip;
			default: return irq;
		endcase
	endfunction
	task automatic wait_sig(input int s, input logic v, output int c);
		c = 0;
		while (pick(s) !== v && c < 500) begin
			@(posedge clk);
			c++;
		end
		if (c >= 500)
			n_fail++;
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#1000000;
		n_fail++;
		finish_test;
	end

	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("reset out", 6'b011100, {drive_en, brake, dir_ccw, is_static, trip, irq});
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr)
				apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			chk("reg", {rows[i].e, rows[i].q}, {err, rd});
		end
		apb(1'b1, `OFS_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		chk("dir", 1'b0, dir_ccw);
		apb(1'b1, `OFS_CTRL, 32'h3);
		repeat (3) @(posedge clk);
		chk("dir", 1'b1, dir_ccw);
		// Servo-on only once the parameters are set
		servo_on <= 1'b1;
		wait_sig(0, 1'b1, n);
		chk("brake on", 1'b0, brake);
		foreach (spd[i]) begin
			@(posedge clk);
			cmd <= spd[i];
			repeat (4) @(posedge clk);
			chk("static", st_exp[i], is_static);
		end
		servo_on <= 1'b0;
		wait_sig(1, 1'b1, n);
		chk("brake first", 1'b1, drive_en);
		wait_sig(0, 1'b0, n);
		chk_rng("soff delay", 2 * TK, 2 * TK + 4, n);
		apb(1'b1, `OFS_IRQ_EN, 32'h4);
		servo_on <= 1'b1;
		wait_sig(0, 1'b1, n);
		alarm <= 1'b1;
		wait_sig(0, 1'b0, n);
		chk_rng("alarm off", 1, 5, n);
		chk("alarm brake", 1'b1, brake);
		wait_sig(3, 1'b1, n);
		chk_rng("irq", 0, 4, n);
		apb(1'b1, `OFS_IRQ_EN, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq mask", 1'b0, irq);
		apb(1'b1, `OFS_IRQ_EN, 32'h4);
		alarm <= 1'b0;
		apb(1'b1, `OFS_IRQ_CLR, 32'h4);
		repeat (2) @(posedge clk);
		chk("irq clr", 1'b0, irq);
		cmd <= 16'sd1000;
		wait_sig(0, 1'b1, n);
		repeat (4) @(posedge clk);
		alarm <= 1'b1;
		wait_sig(0, 1'b0, n);
		chk("coast", 1'b0, brake);
		wait_sig(1, 1'b1, n);
		chk_rng("stop delay", 10 * TK - 2, 10 * TK + 4, n);
		alarm <= 1'b0;
		decel <= 8'd20;
		wait_sig(0, 1'b1, n);
		repeat (4) @(posedge clk);
		servo_on <= 1'b0;
		wait_sig(0, 1'b0, n);
		wait_sig(1, 1'b1, n);
		chk_rng("thr brake", 38, 46, n);
		for (int s = 3; s <= 6; s += 3) begin
			apb(1'b1, `OFS_OVL_SENS, 32'(s));
			overload <= 1'b1;
			wait_sig(2, 1'b1, n);
			// Free running tick: first count lands anywhere within one tick
			chk_rng("overload", (s - 1) * TK + 5, (s + 1) * TK + 4, n);
			overload <= 1'b0;
			wait_sig(2, 1'b0, n);
		end
		finish_test;
	end
endmodule

// [tick_timer.sv]
// Restartable delay timer counted in 10 ms ticks
`include "servo_brake_defines.svh"
module tick_timer #(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int W = 9
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Control
	input wire logic start_i,
	input wire logic [W-1:0] units_i,
	output logic done_o
);
	localparam int PW = $clog2(TICK_CYCLES);
	logic [PW-1:0] pre_reg;
	logic [W-1:0] cnt_reg;
	logic run_reg;

	// A new start throws away any count in progress
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pre_reg <= '0;
			cnt_reg <= '0;
			run_reg <= 1'b0;
			done_o <= 1'b0;
		end else if (start_i) begin
			pre_reg <= '0;
			cnt_reg <= units_i;
			run_reg <= (units_i != '0);
			done_o <= (units_i == '0);
		end else if (run_reg) begin
			if (pre_reg == PW'(TICK_CYCLES - 1)) begin
				pre_reg <= '0;
				cnt_reg <= cnt_reg - W'(1);
				if (cnt_reg <= W'(1)) begin
					run_reg <= 1'b0;
					done_o <= 1'b1;
				end
			end else begin
				pre_reg <= pre_reg + PW'(1);
			end
		end
	end
endmodule
